/* File: rtl/l3ht_pkg.sv */
// event select constants, register map and carrier types
// assumes one uncore clock shared with the apb slave
package l3ht_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CNT_LO = 8'h04;
  localparam logic [7:0] ADDR_CNT_HI = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam int CTRL_EVT_LSB = 0;
  localparam int CTRL_UMASK_LSB = 8;
  localparam int CTRL_EN_BIT = 16;
  localparam logic [16:0] CTRL_RESET = 17'h00000;
  localparam int STAT_IO_LSB = 0;
  localparam int STAT_REM_LSB = 8;
  localparam int STAT_LOC_LSB = 16;
  localparam int STAT_CAT_LSB = 24;
  localparam logic [7:0] EV_FILL = 8'h0a;
  localparam logic [7:0] EV_VICTIM = 8'h0b;
  localparam logic [7:0] EV_REQ = 8'h20;
  localparam logic [7:0] EV_FULL = 8'h21;
  localparam logic [7:0] EV_BUSY = 8'h22;
  localparam logic [7:0] EV_OCC = 8'h23;
  localparam logic [7:0] EV_CONFLICT = 8'h24;
  localparam logic [7:0] UM_FILL_ANY = 8'h0f;
  localparam logic [7:0] UM_VIC_ANY = 8'h1f;
  localparam int UM_CONF_2WAY_BIT = 1;
  localparam int UM_CONF_3WAY_BIT = 2;
  localparam logic [1:0] DEPTH_ALLOC = 2'h2;
  localparam logic [1:0] DEPTH_MAX = 2'h3;
  localparam int TRK_IO = 0;
  localparam int TRK_REM = 1;
  localparam int TRK_LOC = 2;
  localparam int TRK_N = 3;
  localparam int TRK_CW = 8;
  localparam int INC_W = 10;
  typedef enum logic [2:0] {
    COH_M = 3'h0,
    COH_E = 3'h1,
    COH_S = 3'h2,
    COH_I = 3'h3,
    COH_F = 3'h4
  } l3ht_coh_t;
  typedef struct packed {
    logic valid;
    l3ht_coh_t state;
  } l3ht_fill_t;
  typedef struct packed {
    logic valid;
    l3ht_coh_t state;
    logic home_remote;
  } l3ht_victim_t;
  typedef struct packed {
    logic rd_req;
    logic wr_req;
    logic [TRK_CW-1:0] valid_cnt;
    logic [TRK_CW-1:0] rd_cnt;
  } l3ht_trk_t;
endpackage

/* File: rtl/l3ht_event_select.sv */
// event select, conflict table and event counter behind an apb slave
// assumes event inputs are single-cycle pulses from same-clock logic
//
// Operation
// [R1] fill 0x0a umask 0x08 counts F fills
// [R2] fill 0x0a umask 0x0f counts all fills
// [R3] victim 0x0b umask bits pick states
// [R4] modified victim written back to home
// [R5] victim 0x0b umask 0x1f counts all
// [R6] request 0x20 io hub reads, writes
// [R7] request 0x20 remote reads, writes
// [R8] request 0x20 local reads, writes
// [R9] 0x21 counts cycles tracker fully occupied
// [R10] 0x22 counts cycles tracker not empty
// [R11] 0x23 accumulates tracker read occupancy
// [R12] 0x24 counts entries by conflict depth
// [R13] conflict depth reported at deallocation only
// [R14] conflict table holds pointers, not requests
// [R15] match 8-bit event, union of umask bits
// [R16] occupancy adds tracker read count per cycle
`timescale 1ns/10ps
`default_nettype none
module l3ht_event_select #(
  parameter int CNT_W = 48,
  parameter int CAT_N = 8,
  parameter logic [7:0] DEPTH_IO = 8'h20,
  parameter logic [7:0] DEPTH_REM = 8'h20,
  parameter logic [7:0] DEPTH_LOC = 8'h20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire l3ht_pkg::l3ht_fill_t fill_ev,
  input wire l3ht_pkg::l3ht_victim_t victim_ev,
  input wire l3ht_pkg::l3ht_trk_t [2:0] trk,
  input wire logic cat_alloc,
  input wire logic [$clog2(CAT_N)-1:0] cat_alloc_idx,
  input wire logic [7:0] cat_alloc_ptr,
  input wire logic cat_conflict,
  input wire logic [$clog2(CAT_N)-1:0] cat_conflict_idx,
  input wire logic cat_dealloc,
  input wire logic [$clog2(CAT_N)-1:0] cat_dealloc_idx,
  output logic wb_req,
  output logic wb_remote
);
  import l3ht_pkg::*;
  localparam int CIW = $clog2(CAT_N);

  // refuse widths the read path and table count cannot serve
  if (CNT_W < 33 || CNT_W > 64 ||
      CAT_N < 2 || CAT_N > 255) begin : g_bad_param
    $error("l3ht_event_select: unsupported parameters");
  end

  // apb slave
  logic [16:0] ctrl_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic wb_req_reg;
  logic wb_remote_reg;
  logic [CAT_N-1:0] cat_valid_reg;
  logic [1:0] cat_depth_reg [CAT_N];
  logic [7:0] cat_ptr_reg [CAT_N];

  wire logic [7:0] evt = ctrl_reg[CTRL_EVT_LSB +: 8];
  wire logic [7:0] umask = ctrl_reg[CTRL_UMASK_LSB +: 8];
  wire logic enable = ctrl_reg[CTRL_EN_BIT];
  wire logic acc_first = psel && penable && !pready_reg;
  wire logic acc_done = psel && penable && pready_reg;
  wire logic wr_done = acc_done && pwrite;
  wire logic hit_ctrl = paddr == ADDR_CTRL;
  wire logic hit_lo = paddr == ADDR_CNT_LO;
  wire logic hit_hi = paddr == ADDR_CNT_HI;
  wire logic hit_stat = paddr == ADDR_STATUS;
  wire logic addr_ok = hit_ctrl || hit_lo || hit_hi || hit_stat;
  wire logic ctrl_wr = wr_done && hit_ctrl;
  wire logic cnt_clr = wr_done && hit_lo;
  wire logic [63:0] cnt_wide = 64'(cnt_reg);
  wire logic [7:0] cat_used = 8'($countones(cat_valid_reg));
  wire logic [31:0] stat_word = {cat_used,
    trk[TRK_LOC].valid_cnt, trk[TRK_REM].valid_cnt,
    trk[TRK_IO].valid_cnt};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {15'h0000, ctrl_reg} :
    hit_lo ? cnt_wide[31:0] :
    hit_hi ? cnt_wide[63:32] :
    hit_stat ? stat_word : 32'h00000000;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= acc_first;
      pslverr_reg <= acc_first && !addr_ok;
      prdata_reg <= acc_first && !pwrite ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= pwdata[16:0];
    end
  end

  // fill and victim matching
  function automatic logic [7:0] fill_bit(l3ht_coh_t s);
    case (s)
      COH_M: fill_bit = 8'h01;
      COH_E: fill_bit = 8'h02;
      COH_S: fill_bit = 8'h04;
      COH_F: fill_bit = 8'h08;
      default: fill_bit = 8'h00;
    endcase
  endfunction

  wire logic [7:0] vic_bit = 8'h01 << victim_ev.state;
  wire logic fill_any = umask == UM_FILL_ANY; // R2
  wire logic fill_hit = fill_ev.valid &&
    (fill_any || (umask & fill_bit(fill_ev.state)) != 8'h00); // R1
  wire logic vic_any = umask == UM_VIC_ANY; // R5
  wire logic vic_hit = victim_ev.valid &&
    (vic_any || (umask & vic_bit) != 8'h00); // R3

  // per-tracker terms, io hub, remote, local
  logic [5:0] req_hit;
  logic [2:0] full_hit;
  logic [2:0] busy_hit;
  logic [TRK_CW-1:0] occ_term [TRK_N];
  for (genvar t = 0; t < TRK_N; t++) begin : g_trk
    wire logic [7:0] depth = t == TRK_IO ? DEPTH_IO :
      t == TRK_REM ? DEPTH_REM : DEPTH_LOC;
    assign req_hit[2*t] = umask[2*t] && trk[t].rd_req; // R6 R7 R8
    assign req_hit[2*t+1] = umask[2*t+1] && trk[t].wr_req; // R6 R7 R8
    assign full_hit[t] = umask[t] && trk[t].valid_cnt == depth; // R9
    assign busy_hit[t] = umask[t] && trk[t].valid_cnt != 8'h00; // R10
    assign occ_term[t] = umask[t] ? trk[t].rd_cnt : 8'h00; // R11
  end

  wire logic [INC_W-1:0] req_inc = INC_W'($countones(req_hit));
  wire logic [INC_W-1:0] occ_inc = INC_W'(occ_term[0]) +
    INC_W'(occ_term[1]) + INC_W'(occ_term[2]); // R16

  // conflict table: depth and tracker pointer only
  wire logic dealloc_live = cat_dealloc && cat_valid_reg[cat_dealloc_idx];
  wire logic [1:0] dealloc_depth = cat_depth_reg[cat_dealloc_idx];
  wire logic conf_hit = dealloc_live && ( // R13
    (umask[UM_CONF_2WAY_BIT] && dealloc_depth <= DEPTH_ALLOC) ||
    (umask[UM_CONF_3WAY_BIT] && dealloc_depth == DEPTH_MAX)); // R12

  for (genvar e = 0; e < CAT_N; e++) begin : g_cat
    wire logic alloc_e = cat_alloc && cat_alloc_idx == CIW'(e);
    wire logic conf_e = cat_conflict && cat_conflict_idx == CIW'(e);
    wire logic free_e = cat_dealloc && cat_dealloc_idx == CIW'(e);
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        cat_valid_reg[e] <= 1'b0;
        cat_depth_reg[e] <= 2'h0;
        cat_ptr_reg[e] <= 8'h00;
      end else if (alloc_e) begin
        cat_valid_reg[e] <= 1'b1; // R14
        cat_depth_reg[e] <= DEPTH_ALLOC;
        cat_ptr_reg[e] <= cat_alloc_ptr; // R14
      end else if (free_e) begin
        cat_valid_reg[e] <= 1'b0;
      end else if (conf_e && cat_valid_reg[e] &&
                   cat_depth_reg[e] != DEPTH_MAX) begin
        cat_depth_reg[e] <= cat_depth_reg[e] + 2'h1;
      end
    end
  end

  // event select and counter
  logic [INC_W-1:0] inc;
  always_comb begin
    case (evt) // R15
      EV_FILL: inc = INC_W'(fill_hit);
      EV_VICTIM: inc = INC_W'(vic_hit);
      EV_REQ: inc = req_inc;
      EV_FULL: inc = INC_W'(|full_hit);
      EV_BUSY: inc = INC_W'(|busy_hit);
      EV_OCC: inc = occ_inc;
      EV_CONFLICT: inc = INC_W'(conf_hit);
      default: inc = '0;
    endcase
  end

  assign cnt_next = cnt_clr ? '0 :
    enable ? cnt_reg + CNT_W'(inc) : cnt_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // modified victims go back to their home agent
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_req_reg <= 1'b0;
      wb_remote_reg <= 1'b0;
    end else begin
      wb_req_reg <= victim_ev.valid && victim_ev.state == COH_M; // R4
      wb_remote_reg <= victim_ev.home_remote;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign wb_req = wb_req_reg;
  assign wb_remote = wb_remote_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire logic live = enable && !cnt_clr;
  wire logic [CNT_W-1:0] req_n = CNT_W'($countones(umask[5:0] &
    {trk[2].wr_req, trk[2].rd_req, trk[1].wr_req, trk[1].rd_req,
     trk[0].wr_req, trk[0].rd_req}));
  wire logic [2:0] full_n = umask[2:0] & {trk[2].valid_cnt == DEPTH_LOC,
    trk[1].valid_cnt == DEPTH_REM, trk[0].valid_cnt == DEPTH_IO};
  wire logic [2:0] busy_n = umask[2:0] & {trk[2].valid_cnt != 8'h00,
    trk[1].valid_cnt != 8'h00, trk[0].valid_cnt != 8'h00};
  wire logic [CNT_W-1:0] occ_n =
    (umask[0] ? CNT_W'(trk[0].rd_cnt) : CNT_W'(0)) +
    (umask[1] ? CNT_W'(trk[1].rd_cnt) : CNT_W'(0)) +
    (umask[2] ? CNT_W'(trk[2].rd_cnt) : CNT_W'(0));

  fill_f_a: assert property ( // R1
    live && evt == EV_FILL && umask == 8'h08 && fill_ev.valid &&
    fill_ev.state == COH_F |=> cnt_reg == $past(cnt_reg) + 1)
    else $error("f-state fill not counted");

  fill_any_a: assert property ( // R2
    live && evt == EV_FILL && umask == UM_FILL_ANY &&
    fill_ev.valid |=> cnt_reg == $past(cnt_reg) + 1)
    else $error("fill not counted for any-state mask");

  vic_state_a: assert property ( // R3
    live && evt == EV_VICTIM && victim_ev.valid &&
    (umask & vic_bit) == 8'h00 && !vic_any
    |=> cnt_reg == $past(cnt_reg))
    else $error("victim counted in unselected state");

  sequence vic_mod_s;
    victim_ev.valid && victim_ev.state == COH_M;
  endsequence
  wb_home_a: assert property ( // R4
    vic_mod_s |=> wb_req && wb_remote == $past(victim_ev.home_remote)
    ##1 !wb_req || $past(victim_ev.valid))
    else $error("modified victim not written back");

  vic_any_a: assert property ( // R5
    live && evt == EV_VICTIM && umask == UM_VIC_ANY &&
    victim_ev.valid |=> cnt_reg == $past(cnt_reg) + 1)
    else $error("victim not counted for any-state mask");

  req_cnt_a: assert property ( // R6 R7 R8
    live && evt == EV_REQ |=> cnt_reg == $past(cnt_reg) + $past(req_n))
    else $error("tracker request count wrong");

  full_cyc_a: assert property ( // R9
    live && evt == EV_FULL && full_n != 3'h0
    |=> cnt_reg == $past(cnt_reg) + 1)
    else $error("full cycle missed");

  busy_cyc_a: assert property ( // R10
    live && evt == EV_BUSY && busy_n == 3'h0
    |=> cnt_reg == $past(cnt_reg))
    else $error("idle tracker counted busy");

  busy_set_a: assert property ( // R10
    live && evt == EV_BUSY && busy_n != 3'h0
    |=> cnt_reg == $past(cnt_reg) + 1)
    else $error("busy tracker cycle missed");

  occ_sum_a: assert property ( // R11 R16
    live && evt == EV_OCC |=> cnt_reg ==
    $past(cnt_reg) + $past(occ_n))
    else $error("occupancy sum wrong");

  sequence cat_fill_s;
    cat_alloc && !cat_dealloc && !cat_conflict ##1
    !cat_alloc && !cat_dealloc ##1
    cat_conflict && cat_conflict_idx == $past(cat_alloc_idx, 2) &&
    !cat_alloc && !cat_dealloc ##1
    !cat_alloc && !cat_dealloc;
  endsequence
  conf_depth_a: assert property ( // R12
    cat_fill_s ##1 live && evt == EV_CONFLICT && umask == 8'h04 &&
    !cat_alloc && cat_dealloc &&
    cat_dealloc_idx == $past(cat_conflict_idx, 2)
    |=> cnt_reg == $past(cnt_reg) + 1)
    else $error("three-way conflict entry not counted");

  sequence cat_new_s;
    cat_alloc && !cat_dealloc && !cat_conflict ##1
    !cat_alloc && !cat_dealloc && !cat_conflict;
  endsequence
  conf_two_a: assert property ( // R12
    cat_new_s ##1 live && evt == EV_CONFLICT && umask == 8'h02 &&
    !cat_alloc && cat_dealloc &&
    cat_dealloc_idx == $past(cat_alloc_idx, 2)
    |=> cnt_reg == $past(cnt_reg) + 1)
    else $error("two-way conflict entry not counted");

  conf_late_a: assert property ( // R13
    live && evt == EV_CONFLICT && !cat_dealloc
    |=> cnt_reg == $past(cnt_reg))
    else $error("conflict counted before deallocation");

  cat_ptr_a: assert property ( // R14
    cat_alloc |=> cat_valid_reg[$past(cat_alloc_idx)] &&
    cat_ptr_reg[$past(cat_alloc_idx)] == $past(cat_alloc_ptr))
    else $error("conflict entry pointer not held");

  no_sel_a: assert property ( // R15
    live && inc == '0 |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved without a selected event");

  wb_quiet_a: assert property ( // R4
    !(victim_ev.valid && victim_ev.state == COH_M) |=> !wb_req)
    else $error("writeback without a modified victim");

  bad_addr_a: assert property (
    psel && penable && !pready && paddr > ADDR_STATUS
    |=> pready && pslverr && prdata == 32'h00000000)
    else $error("unmapped address not refused");

  clr_win_a: assert property (
    psel && penable && pready && pwrite && paddr == ADDR_CNT_LO
    |=> cnt_reg == '0)
    else $error("counter clear lost to an event");

  ctrl_wr_a: assert property (
    psel && penable && pready && pwrite && paddr == ADDR_CTRL
    |=> ctrl_reg == $past(pwdata[16:0]))
    else $error("control write did not land");

  apb_ans_a: assert property (
    acc_first |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
endmodule // l3ht_event_select
`default_nettype wire

/* File: testbench/l3ht_partner.sv */
// far-side model: cache fill and victim, trackers, conflict table
// assumes one caller process and the uncore clock
`timescale 1ns/10ps
`default_nettype none
module l3ht_partner (
  input wire logic clk,
  output var l3ht_pkg::l3ht_fill_t fill_ev,
  output var l3ht_pkg::l3ht_victim_t victim_ev,
  output var l3ht_pkg::l3ht_trk_t [2:0] trk,
  output var logic [2:0] cat_op,
  output var logic [2:0] cat_idx,
  output var logic [7:0] cat_ptr
);
  import l3ht_pkg::*;
  initial begin
    fill_ev = '0;
    victim_ev = '0;
    trk = '0;
    cat_op = 3'h0;
    cat_idx = 3'h0;
    cat_ptr = 8'h00;
  end
  task automatic fill(input l3ht_coh_t s);
    @(posedge clk);
    fill_ev <= '{1'b1, s};
    @(posedge clk);
    fill_ev <= '{1'b0, l3ht_coh_t'(~s)};
  endtask
  task automatic victim(input l3ht_coh_t s, input logic r);
    @(posedge clk);
    victim_ev <= '{1'b1, s, r};
    @(posedge clk);
    victim_ev <= '{1'b0, l3ht_coh_t'(~s), ~r};
  endtask
  task automatic req(input int t, input logic w);
    @(posedge clk);
    trk[t].rd_req <= !w;
    trk[t].wr_req <= w;
    @(posedge clk);
    trk[t].rd_req <= 1'b0;
    trk[t].wr_req <= 1'b0;
  endtask
  task automatic lvl(input int t, input logic [7:0] v, r);
    @(posedge clk);
    trk[t].valid_cnt <= v;
    trk[t].rd_cnt <= r;
  endtask
  // op bits: alloc, conflict, dealloc
  task automatic cat(input logic [2:0] op, input logic [2:0] i);
    @(posedge clk);
    cat_op <= op;
    cat_idx <= i;
    cat_ptr <= {5'h00, ~i};
    @(posedge clk);
    cat_op <= 3'h0;
    cat_idx <= ~i;
  endtask
endmodule // l3ht_partner
`default_nettype wire

/* File: testbench/l3_home_tracker_event_select_tb_top.sv */
// testbench: apb master plus hand-written event scenarios
// assumes the far-side model drives all event inputs
`timescale 1ns/10ps
`default_nettype none
module l3_home_tracker_event_select_tb_top;
  import l3ht_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, wb_req, wb_remote;
  l3ht_fill_t fill_ev;
  l3ht_victim_t victim_ev;
  l3ht_trk_t [2:0] trk;
  logic [2:0] op, idx;
  logic [7:0] ptr;
  int n_mismatch = 0;
  int cmp_count = 0;
  int wb_seen = 0;
  int wb_rem_seen = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (wb_req === 1'b1) wb_seen++;
    if (wb_req === 1'b1 && wb_remote === 1'b1) wb_rem_seen++;
  end
  l3ht_event_select u_l3ht_event_select (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fill_ev(fill_ev), .victim_ev(victim_ev),
    .trk(trk), .cat_alloc(op[2]), .cat_alloc_idx(idx),
    .cat_alloc_ptr(ptr), .cat_conflict(op[1]), .cat_conflict_idx(idx),
    .cat_dealloc(op[0]), .cat_dealloc_idx(idx), .wb_req(wb_req),
    .wb_remote(wb_remote));
  l3ht_partner u_l3ht_partner (.clk(clk), .fill_ev(fill_ev),
    .victim_ev(victim_ev), .trk(trk), .cat_op(op), .cat_idx(idx),
    .cat_ptr(ptr));
  task automatic summarize;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      summarize;
    end
  endtask
  task automatic arm(input logic [31:0] c);
    apb(1'b1, ADDR_CTRL, c);
    apb(1'b1, ADDR_CNT_LO, 32'h0);
  endtask
  task automatic chk(input logic [31:0] e);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b0, ADDR_CNT_LO, 32'h0);
    cmp(rd, e);
  endtask
  task automatic t_regs;
    apb(1'b0, ADDR_CTRL, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    cmp({rd[30:0], er}, 32'h1);
  endtask
  task automatic t_cache;
    arm(32'h1080a);
    for (int s = 0; s < 5; s++) u_l3ht_partner.fill(l3ht_coh_t'(s));
    chk(32'h1);
    arm(32'h10f0a);
    for (int s = 0; s < 5; s++) u_l3ht_partner.fill(l3ht_coh_t'(s));
    chk(32'h5);
    for (int m = 0; m < 6; m++) begin
      arm(m < 5 ? 32'h1000b | (32'h100 << m) : 32'h11f0b);
      for (int s = 0; s < 5; s++)
        u_l3ht_partner.victim(l3ht_coh_t'(s), 1'(m));
      chk(m < 5 ? 32'h1 : 32'h5);
    end
    cmp(32'(wb_seen), 32'h6);
    cmp(32'(wb_rem_seen), 32'h3);
  endtask
  task automatic t_req;
    for (int b = 0; b < 7; b++) begin
      arm(b < 6 ? 32'h10020 | (32'h100 << b) : 32'h13f20);
      for (int t = 0; t < 6; t++) u_l3ht_partner.req(t / 2, 1'(t % 2));
      chk(b < 6 ? 32'h1 : 32'h6);
    end
  endtask
  task automatic t_lvl(input logic [31:0] c, input int t,
                       input logic [7:0] v, r, input logic [31:0] e);
    arm(c);
    u_l3ht_partner.lvl(t, v, r);
    repeat (3) @(posedge clk);
    u_l3ht_partner.lvl(t, 8'h00, 8'h00);
    chk(e);
  endtask
  task automatic t_conf;
    arm(32'h10424);
    u_l3ht_partner.cat(3'h4, 3'h5);
    u_l3ht_partner.cat(3'h2, 3'h5);
    apb(1'b0, ADDR_STATUS, 32'h0);
    cmp(rd, 32'h01000000);
    apb(1'b0, ADDR_CNT_LO, 32'h0);
    cmp(rd, 32'h0);
    u_l3ht_partner.cat(3'h1, 3'h5);
    chk(32'h1);
    arm(32'h10424);
    u_l3ht_partner.cat(3'h4, 3'h1);
    u_l3ht_partner.cat(3'h2, 3'h1);
    u_l3ht_partner.cat(3'h1, 3'h1);
    chk(32'h1);
    arm(32'h10224);
    u_l3ht_partner.cat(3'h4, 3'h2);
    u_l3ht_partner.cat(3'h1, 3'h2);
    u_l3ht_partner.cat(3'h4, 3'h3);
    u_l3ht_partner.cat(3'h2, 3'h3);
    u_l3ht_partner.cat(3'h2, 3'h3);
    u_l3ht_partner.cat(3'h1, 3'h3);
    chk(32'h1);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_cache;
    t_req;
    t_lvl(32'h10221, TRK_REM, 8'h20, 8'h00, 32'h4);
    t_lvl(32'h10121, TRK_REM, 8'h20, 8'h00, 32'h0);
    t_lvl(32'h10221, TRK_REM, 8'h1f, 8'h00, 32'h0);
    t_lvl(32'h10422, TRK_LOC, 8'h01, 8'h00, 32'h4);
    t_lvl(32'h10123, TRK_IO, 8'h05, 8'h03, 32'hc);
    t_conf;
    summarize;
  end
endmodule // l3_home_tracker_event_select_tb_top
`default_nettype wire
